// File: logic/sadc_pkg.sv
package sadc_pkg;
    // result and frame layout
    localparam int RES_W = 12;
    localparam int PAD_W = 4;
    localparam int FRAME_W = RES_W + PAD_W;
    // conversion runs on the serial clock halved
    localparam int CONV_CLKS = 14;
    localparam int CONV_SCLKS = 2 * CONV_CLKS;
    // sampling window, counted in falling serial clock edges
    localparam int SAMPLE_FIRST = 5;
    localparam int SAMPLE_LEN = 12;
    localparam int START_FALL = 16;
    // result queue depth
    localparam int FIFO_DEPTH = 8;
    // width of the edge counters
    localparam int CNT_W = 6;
    // clipped codes
    localparam logic [11:0] CODE_FULL = 12'hfff;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    // the converter comes out of reset powered down
    localparam logic PD_RESET = 1'b1;
    // frame sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_CONV,
        ST_PUSH
    } sadc_state_e;
endpackage

// File: logic/sadc_fifo.sv
module sadc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    // pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    logic [AW:0] cnt_q; // words held
    logic push; // accepted write
    logic pop; // accepted read

    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign push = clk_en & in_valid & in_ready;
    assign pop = clk_en & out_valid & out_ready;
    assign out_data = mem[rd_q];

    // storage has no reset; empty words are never read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    chk_no_overflow: assert property (@(posedge clock) disable iff (!arst_n)
        cnt_q <= FULL)
        else $error("fifo level above depth");
endmodule

// File: logic/sadc_ctrl.sv
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - conversion takes 28 serial clocks, halved
// - early frame end aborts, next data invalid
// - select falling edge starts cycle, select-only
// - optional output update on falling clock edges
// - select falling edge presents result MSB
// - frame-sync rising edge presents MSB, no select
// - frame-sync falls while clock high, starts cycle
// - clip: all ones above, zeros below
// - power down when conversion completes
// - wake on select fall or frame-sync rise
// - 16-bit frame, MSB first, 12-bit result
// - sample 12 clocks from fifth clock
// - conversion starts after sixteenth falling edge
// - frame returns previous frame's conversion
module sadc_ctrl #(
    parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic frame_sync_in,
    input wire logic fs_mode,
    input wire logic shift_on_fall,
    input wire logic [11:0] adc_code,
    input wire logic adc_above_ref,
    input wire logic adc_below_gnd,
    output logic sdo,
    output logic sdo_oe,
    output logic data_invalid,
    output logic sample_en,
    output logic converting,
    output logic conv_clk,
    output logic power_down
);
    localparam int RW = sadc_pkg::RES_W;
    localparam int FW = sadc_pkg::FRAME_W;
    localparam int CW = sadc_pkg::CNT_W;
    localparam logic [CW-1:0] SAMP_LO = CW'(sadc_pkg::SAMPLE_FIRST - 1);
    localparam logic [CW-1:0] SAMP_HI =
        CW'(sadc_pkg::SAMPLE_FIRST + sadc_pkg::SAMPLE_LEN - 2);
    localparam logic [CW-1:0] LAST_FALL = CW'(sadc_pkg::START_FALL - 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(sadc_pkg::CONV_SCLKS - 1);
    localparam logic [CW-1:0] BITS_OUT = CW'(FW);

    if (sadc_pkg::START_FALL < sadc_pkg::SAMPLE_FIRST + sadc_pkg::SAMPLE_LEN - 1
        || DEPTH < 2) begin : g_bad
        $error("sampling window or queue depth out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // edge detection on the host pins

    logic sclk_q; // serial clock, previous sample
    logic cs_q; // select, previous sample
    logic fs_q; // frame sync, previous sample
    logic sclk_rise, sclk_fall; // serial clock edges
    logic cs_fall, cs_rise; // select edges
    logic fs_fall, fs_rise; // frame sync edges
    logic start; // cycle start
    logic frame_end; // active frame released
    logic release_msb; // present a new word on the output

    // pins are synchronous, so one flop of history suffices
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            fs_q <= 1'b1;
        end else if (clk_en) begin
            sclk_q <= sclk_in;
            cs_q <= cs_n_in;
            fs_q <= frame_sync_in;
        end
    end

    assign sclk_rise = clk_en & sclk_in & ~sclk_q;
    assign sclk_fall = clk_en & ~sclk_in & sclk_q;
    assign cs_fall = clk_en & ~cs_n_in & cs_q;
    assign cs_rise = clk_en & cs_n_in & ~cs_q;
    assign fs_fall = clk_en & ~frame_sync_in & fs_q;
    assign fs_rise = clk_en & frame_sync_in & ~fs_q;

    // frame sync only counts while the clock is high
    assign start = fs_mode ? (fs_fall & sclk_in) : cs_fall;
    // select release or frame-sync release closes the frame
    assign frame_end = cs_rise | (fs_mode & fs_rise);
    // select fall, or frame-sync rise when select is tied low
    assign release_msb = cs_fall
        | (fs_mode & fs_rise & ~cs_n_in & ~sdo_oe);

    //////////////////////////////////////////////////////////////////////////
    // frame sequencer

    sadc_pkg::sadc_state_e state_q; // sequencer state
    logic [CW-1:0] fall_cnt_q; // falling edges since start
    logic [CW-1:0] conv_cnt_q; // falling edges in conversion
    logic [RW-1:0] res_q; // held sample, clipped
    logic bad_q; // queued word is an aborted one
    logic push_ready; // queue accepts a word
    logic capture; // end of sampling window
    logic conv_done; // last conversion clock

    assign capture = (state_q == sadc_pkg::ST_FRAME) & sclk_fall
        & (fall_cnt_q == LAST_FALL) & ~frame_end & ~start;
    // a restart on the last fall wins, so the word is not pushed twice
    assign conv_done = (state_q == sadc_pkg::ST_CONV) & sclk_fall
        & (conv_cnt_q == CONV_LAST) & ~frame_end & ~start;

    // a start while a word waits for the queue is refused,
    // otherwise that frame's result would be dropped silently
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= sadc_pkg::ST_IDLE;
            bad_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                sadc_pkg::ST_PUSH: begin
                    // hold until the queue takes the word
                    if (push_ready) begin
                        state_q <= sadc_pkg::ST_IDLE;
                    end
                end
                sadc_pkg::ST_FRAME, sadc_pkg::ST_CONV: begin
                    if (start) begin
                        // restart drops the partial cycle
                        state_q <= sadc_pkg::ST_FRAME;
                    end else if (frame_end) begin
                        state_q <= sadc_pkg::ST_PUSH;
                        bad_q <= 1'b1;
                    end else if (capture) begin
                        state_q <= sadc_pkg::ST_CONV;
                    end else if (conv_done) begin
                        state_q <= sadc_pkg::ST_PUSH;
                        bad_q <= 1'b0;
                    end
                end
                default: begin
                    if (start) begin
                        state_q <= sadc_pkg::ST_FRAME;
                    end
                end
            endcase
        end
    end

    // edge counters drive sampling and conversion timing
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt_q <= '0;
            conv_cnt_q <= '0;
        end else if (start && state_q != sadc_pkg::ST_PUSH) begin
            fall_cnt_q <= '0;
            conv_cnt_q <= '0;
        end else if (sclk_fall) begin
            if (state_q == sadc_pkg::ST_FRAME) begin
                fall_cnt_q <= fall_cnt_q + 1'b1;
            end
            if (state_q == sadc_pkg::ST_CONV) begin
                conv_cnt_q <= conv_cnt_q + 1'b1;
            end
        end
    end

    // half-rate conversion clock, idle low
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            conv_clk <= 1'b0;
        end else if (clk_en && state_q != sadc_pkg::ST_CONV) begin
            // held while the enable is low, like every other flop
            conv_clk <= 1'b0;
        end else if (sclk_fall) begin
            conv_clk <= ~conv_clk;
        end
    end

    // hold the sample at the close of the window, clipped at the rails
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            res_q <= sadc_pkg::CODE_ZERO;
        end else if (capture) begin
            if (adc_above_ref) begin
                res_q <= sadc_pkg::CODE_FULL;
            end else if (adc_below_gnd) begin
                res_q <= sadc_pkg::CODE_ZERO;
            end else begin
                res_q <= adc_code;
            end
        end
    end

    assign sample_en = (state_q == sadc_pkg::ST_FRAME)
        & (fall_cnt_q >= SAMP_LO) & (fall_cnt_q <= SAMP_HI);
    assign converting = (state_q == sadc_pkg::ST_CONV);

    // asleep after each conversion, awake on the next frame edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            power_down <= sadc_pkg::PD_RESET;
        end else if (cs_fall || (fs_mode && fs_rise)) begin
            power_down <= 1'b0;
        end else if (conv_done) begin
            power_down <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // result queue: one word per frame, read out one frame later

    logic q_valid; // queue holds a result
    logic [RW:0] q_data; // {aborted, code}

    sadc_fifo #(
        .WIDTH(RW + 1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .in_valid(state_q == sadc_pkg::ST_PUSH),
        .in_ready(push_ready),
        .in_data({bad_q, res_q}),
        .out_valid(q_valid),
        .out_ready(release_msb),
        .out_data(q_data)
    );

    //////////////////////////////////////////////////////////////////////////
    // serial output

    logic [FW-1:0] shift_q; // outgoing frame
    logic [CW-1:0] bit_cnt_q; // shift edges seen
    logic shift_edge; // edge that moves the data

    // on falling mode the first fall is where the host reads the MSB
    assign shift_edge = shift_on_fall
        ? (sclk_fall & (bit_cnt_q != '0 | fall_cnt_q != '0))
        : sclk_rise;
    assign sdo = shift_q[FW-1];

    // load on release, shift MSB first, float after the last bit
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
            sdo_oe <= 1'b0;
            data_invalid <= 1'b0;
        end else if (release_msb) begin
            // empty queue gives zeros flagged invalid
            shift_q <= q_valid ? {q_data[RW-1:0], {sadc_pkg::PAD_W{1'b0}}}
                : '0;
            data_invalid <= q_valid ? q_data[RW] : 1'b1;
            bit_cnt_q <= '0;
            sdo_oe <= 1'b1;
        end else if (cs_rise) begin
            sdo_oe <= 1'b0;
        end else if (sdo_oe && shift_edge) begin
            shift_q <= {shift_q[FW-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == BITS_OUT) begin
                sdo_oe <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks

    chk_conv_len_end: assert property (
        @(posedge clock) disable iff (!arst_n)
        conv_done |=> state_q == sadc_pkg::ST_PUSH && !bad_q)
        else $error("conversion did not end after 28 clocks");
    chk_abort_marks_bad: assert property (
        @(posedge clock) disable iff (!arst_n)
        (state_q == sadc_pkg::ST_CONV) && frame_end && !start
        |=> state_q == sadc_pkg::ST_PUSH && bad_q)
        else $error("early frame end not flagged");
    chk_cs_start: assert property (
        @(posedge clock) disable iff (!arst_n)
        !fs_mode && cs_fall && state_q != sadc_pkg::ST_PUSH
        |=> state_q == sadc_pkg::ST_FRAME && fall_cnt_q == '0)
        else $error("select fall did not start a cycle");
    chk_msb_present: assert property (
        @(posedge clock) disable iff (!arst_n)
        release_msb && q_valid |=> sdo_oe && sdo == $past(q_data[RW-1]))
        else $error("result MSB not presented on release");
    chk_fs_start: assert property (
        @(posedge clock) disable iff (!arst_n)
        fs_mode && fs_fall && sclk_in && state_q == sadc_pkg::ST_IDLE
        |=> state_q == sadc_pkg::ST_FRAME)
        else $error("frame-sync fall did not start a cycle");
    chk_clip_high: assert property (
        @(posedge clock) disable iff (!arst_n)
        capture && adc_above_ref |=> res_q == sadc_pkg::CODE_FULL)
        else $error("over-range input not clipped to full scale");
    chk_pd_entry: assert property (
        @(posedge clock) disable iff (!arst_n)
        conv_done && !cs_fall && !(fs_mode && fs_rise) |=> power_down)
        else $error("no power down after conversion");
    chk_wake_now: assert property (
        @(posedge clock) disable iff (!arst_n)
        cs_fall || (fs_mode && fs_rise) |=> !power_down)
        else $error("no wake on frame edge");
    // the window must open on the fall that ends the fourth clock
    chk_sample_win: assert property (
        @(posedge clock) disable iff (!arst_n)
        state_q == sadc_pkg::ST_FRAME && sclk_fall && !start && !frame_end
        && fall_cnt_q == SAMP_LO - 1'b1 |=> sample_en)
        else $error("sampling window did not open");
    chk_float_after: assert property (
        @(posedge clock) disable iff (!arst_n)
        sdo_oe && shift_edge && bit_cnt_q == BITS_OUT && !release_msb
        && !cs_rise |=> !sdo_oe)
        else $error("output still driven after the frame");
endmodule

// File: test/sadc_host.sv
//////////////////////////////////////////////////////////////////////////////
// host side: drives the serial clock, select and frame sync, reads the data
module sadc_host (
    input wire logic clock,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic data_invalid,
    input wire logic power_down,
    output logic sclk_in,
    output logic cs_n_in,
    output logic frame_sync_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // 10 MHz serial clock, well under the tightest mode limit
    localparam int HALF = 5;
    logic last_q; // last driven level of the data line
    logic line; // level seen on the data line

    // idle pins at time zero: clock still, select and sync high
    initial begin
        sclk_in = 1'b0;
        cs_n_in = 1'b1;
        frame_sync_in = 1'b1;
    end

    // floating line shows the inverse of the last value, never a held bit
    always @(posedge clock) begin
        if (sdo_oe === 1'b1) begin
            last_q <= sdo;
        end
    end
    assign line = (sdo_oe === 1'b1) ? sdo : ~last_q;

    // one half period of the serial clock
    task automatic half_wait();
        repeat (HALF) @(posedge clock);
    endtask

    // one frame of n serial clocks; start edge falls while the clock is high
    // rf: data moves on falling edges, so it is read inside the high phase
    task automatic run_frame(input logic fs, input logic rf, input int n,
            output logic [15:0] w, output logic inv, output logic pd,
            output logic oe_end);
        w = 16'h0000;
        sclk_in <= 1'b1;
        half_wait();
        if (fs) begin
            // select held low, sync pulse releases then starts
            cs_n_in <= 1'b0;
            frame_sync_in <= 1'b1;
            repeat (2) @(posedge clock);
            frame_sync_in <= 1'b0;
        end else begin
            // converter is alone on this port, so sync may drive select
            cs_n_in <= 1'b0;
        end
        half_wait();
        // frame spans data, conversion and one spare clock
        for (int i = 0; i < n; i++) begin
            sclk_in <= 1'b0;
            if (i < 16 && !rf) begin
                w = {w[14:0], line};
            end
            if (i == 0) begin
                inv = data_invalid;
                pd = power_down;
            end
            if (i == 19) begin
                oe_end = sdo_oe;
            end
            half_wait();
            sclk_in <= 1'b1;
            // two clocks in, a rising-edge shift would already show
            repeat (2) @(posedge clock);
            if (i < 16 && rf) begin
                w = {w[14:0], line};
            end
            repeat (HALF - 2) @(posedge clock);
        end
        if (!fs) begin
            cs_n_in <= 1'b1;
        end
        half_wait();
        // a falling clock edge after the frame, with select high unless fs is set
        sclk_in <= 1'b0;
        half_wait();
    endtask
endmodule

// File: test/sadc_ctrl_test.sv
//////////////////////////////////////////////////////////////////////////////
// self-checking bench for the converter frame control
module sadc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, arst_n, clk_en, fs_mode, shift_on_fall;
    logic [11:0] adc_code;
    logic adc_above_ref, adc_below_gnd;
    logic sclk_in, cs_n_in, frame_sync_in;
    logic sdo, sdo_oe, data_invalid, sample_en, converting, conv_clk;
    logic power_down;
    int errors, compares, n_smp, n_cnv, n_cck;
    logic cck_q; // previous conversion clock level
    logic [15:0] w; // word read by the host
    logic inv, pd, oe;

    sadc_ctrl #(.DEPTH(sadc_pkg::FIFO_DEPTH)) dut (.clock(clock),
        .arst_n(arst_n), .clk_en(clk_en), .sclk_in(sclk_in),
        .cs_n_in(cs_n_in), .frame_sync_in(frame_sync_in),
        .fs_mode(fs_mode), .shift_on_fall(shift_on_fall),
        .adc_code(adc_code), .adc_above_ref(adc_above_ref),
        .adc_below_gnd(adc_below_gnd), .sdo(sdo), .sdo_oe(sdo_oe),
        .data_invalid(data_invalid), .sample_en(sample_en),
        .converting(converting), .conv_clk(conv_clk),
        .power_down(power_down));
    sadc_host host (.clock(clock), .sdo(sdo), .sdo_oe(sdo_oe),
        .data_invalid(data_invalid), .power_down(power_down),
        .sclk_in(sclk_in), .cs_n_in(cs_n_in),
        .frame_sync_in(frame_sync_in));

    // 100 MHz clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // cycle counters for sampling, conversion and half-rate clock rises
    always @(posedge clock) begin
        cck_q <= conv_clk;
        if (sample_en === 1'b1) n_smp <= n_smp + 1;
        if (converting === 1'b1) n_cnv <= n_cnv + 1;
        if (conv_clk === 1'b1 && cck_q === 1'b0) n_cck <= n_cck + 1;
    end

    // compare and report
    task automatic check(input string name, input logic [15:0] exp,
            input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // counters cleared while idle, so no increment is pending
    task automatic frame(input logic fs, input int n);
        n_smp = 0;
        n_cnv = 0;
        n_cck = 0;
        host.run_frame(fs, shift_on_fall, n, w, inv, pd, oe);
    endtask

    task automatic t_reset();
        check("oe", 16'h0000, {15'h0000, sdo_oe});
        check("pd", 16'h0001, {15'h0000, power_down});
        check("conv", 16'h0000, {15'h0000, converting});
        $display("t_reset done");
    endtask

    task automatic t_first();
        adc_code <= 12'ha5c;
        frame(1'b0, 45);
        check("word", 16'h0000, w);
        check("inv", 16'h0001, {15'h0000, inv});
        check("wake", 16'h0000, {15'h0000, pd});
        check("smp", 16'h0078, 16'(n_smp));
        check("cnv", 16'h0118, 16'(n_cnv));
        check("cck", 16'h000e, 16'(n_cck));
        check("pd", 16'h0001, {15'h0000, power_down});
        check("oe", 16'h0000, {15'h0000, oe});
        $display("t_first done");
    endtask

    task automatic t_result();
        adc_above_ref <= 1'b1;
        frame(1'b0, 45);
        check("word", 16'ha5c0, w);
        check("inv", 16'h0000, {15'h0000, inv});
        $display("t_result done");
    endtask

    task automatic t_clip();
        adc_above_ref <= 1'b0;
        adc_below_gnd <= 1'b1;
        frame(1'b0, 45);
        check("full", 16'hfff0, w);
        adc_below_gnd <= 1'b0;
        adc_code <= 12'h7e2;
        frame(1'b0, 45);
        check("zero", 16'h0000, w);
        $display("t_clip done");
    endtask

    task automatic t_abort();
        frame(1'b0, 20);
        check("word", 16'h7e20, w);
        check("short", 16'h0001, {15'h0000, n_cnv < 280});
        // an unfinished conversion would still be running here
        check("conv", 16'h0000, {15'h0000, converting});
        adc_code <= 12'h19b;
        frame(1'b0, 45);
        check("inv", 16'h0001, {15'h0000, inv});
        $display("t_abort done");
    endtask

    // data moves on falling clock edges; the host reads in the high phase
    task automatic t_falling();
        shift_on_fall <= 1'b1;
        adc_code <= 12'h3c6;
        // let the mode settle before the host takes it as an argument
        @(posedge clock);
        frame(1'b0, 45);
        check("word", 16'h19b0, w);
        check("inv", 16'h0000, {15'h0000, inv});
        check("oe", 16'h0000, {15'h0000, oe});
        shift_on_fall <= 1'b0;
        @(posedge clock);
        $display("t_falling done");
    endtask

    task automatic t_fsync();
        fs_mode <= 1'b1;
        adc_code <= 12'h2d4;
        frame(1'b1, 45);
        check("word", 16'h3c60, w);
        check("smp", 16'h0078, 16'(n_smp));
        frame(1'b1, 45);
        check("word", 16'h2d40, w);
        check("inv", 16'h0000, {15'h0000, inv});
        $display("t_fsync done");
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        errors = 0;
        compares = 0;
        arst_n = 1'b0;
        clk_en = 1'b1;
        fs_mode = 1'b0;
        shift_on_fall = 1'b0;
        adc_code = 12'h000;
        adc_above_ref = 1'b0;
        adc_below_gnd = 1'b0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_first();
        t_result();
        t_clip();
        t_abort();
        t_falling();
        t_fsync();
        final_report();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        final_report();
    end
endmodule
